// >>> core/virc_pkg.sv
/*
 * constants shared by both ends of the interrupt configuration register link
 * assumes one 100 MHz clock (mclk) and a synchronous active-high reset
 */
// Behaviour
// - registers native in top lane, low byte here
// - ack control: level bits 2-0, mask 7
// - reserved bits 6-3 read as ones
// - seven VME level controls: level, mask
// - DMA done control: level, mask bit 7
// - local line controls: level, mask, pin level
// - software sets autovector bit 4 always
// - lines 2 and 7: bits 5-6 clear
// - global switch control: level, bit3 one, masks
// - module switch control: level, bit3 one, masks
// - error control: level, live sysfail bit 3
// - error masks: sysfail, arbitration, post, acfail
// - switch vector base: bits 1-0 read-only
// - line and error bases form vectors
// - five general bytes writable from both sides
// - read-only revision code on both sides
// - reset control: 1-0 local only, ones
// - fail bit drives sysfail when line7 allows
package virc_pkg;
    localparam int NREG = 31;
    localparam int NPIN = 28;
    localparam int NSRC = 28;
    localparam int NLINE = 7;
    localparam int NSW = 4;
    // device register indices; byte address is four times the index
    localparam logic [7:0] IX_ACK = 8'h00;
    localparam logic [7:0] IX_VLVL1 = 8'h01;
    localparam logic [7:0] IX_DMA = 8'h08;
    localparam logic [7:0] IX_LL1 = 8'h09;
    localparam logic [7:0] IX_LL7 = 8'h0f;
    localparam logic [7:0] IX_GSW = 8'h10;
    localparam logic [7:0] IX_MSW = 8'h11;
    localparam logic [7:0] IX_ERR = 8'h12;
    localparam logic [7:0] IX_GSWVB = 8'h13;
    localparam logic [7:0] IX_MSWVB = 8'h14;
    localparam logic [7:0] IX_LLVB = 8'h15;
    localparam logic [7:0] IX_ERRVB = 8'h16;
    localparam logic [7:0] IX_FLAGS = 8'h17;
    localparam logic [7:0] IX_GP0 = 8'h18;
    localparam logic [7:0] IX_GP4 = 8'h1c;
    localparam logic [7:0] IX_REV = 8'h1d;
    localparam logic [7:0] IX_RFC = 8'h1e;
    // field layout
    localparam int MASK_BIT = 7;
    localparam int LIVE_BIT = 3;
    localparam int FAIL_BIT = 6;
    localparam int EM_SYSF = 4;
    localparam logic [7:0] RSV_ONES = 8'h78;
    localparam logic [7:0] ONE3 = 8'h08;
    localparam logic [7:0] VB_RO = 8'h03;
    localparam logic [7:0] RFC_ONES = 8'h3c;
    localparam logic [7:0] RFC_KEEP = 8'h43;
    localparam logic [7:0] RFC_RESET = 8'h43;
    localparam logic [7:0] RFC_VME_WR = 8'h40;
    // pin vector positions
    localparam int P_VIRQ = 0;
    localparam int P_LINE = 7;
    localparam int P_ACK = 14;
    localparam int P_DMA = 15;
    localparam int P_SYSF = 16;
    localparam int P_ARB = 17;
    localparam int P_WPF = 18;
    localparam int P_ACF = 19;
    localparam int P_GSW = 20;
    localparam int P_MSW = 24;
    // held event flags
    localparam int PD_ACK = 0;
    localparam int PD_DMA = 1;
    localparam int PD_ARB = 2;
    localparam int PD_WPF = 3;
    // source numbers in priority scan
    localparam int S_ACK = 0;
    localparam int S_VLVL = 1;
    localparam int S_DMA = 8;
    localparam int S_LL = 9;
    localparam int S_GSW = 16;
    localparam int S_MSW = 20;
    localparam int S_ERR = 24;
    // host register addresses
    localparam logic [3:0] HA_ADDR = 4'h0;
    localparam logic [3:0] HA_WDATA = 4'h1;
    localparam logic [3:0] HA_CMD = 4'h2;
    localparam logic [3:0] HA_RDATA = 4'h3;
    localparam logic [3:0] HA_STAT = 4'h4;
    localparam logic [3:0] HA_CLR = 4'h5;
    localparam logic [3:0] HA_EN = 4'h6;
    localparam logic [3:0] HA_INFO = 4'h7;
    localparam int CMD_WR = 0;
    localparam int CMD_RD = 1;
    localparam int ST_DONE = 0;
    localparam int ST_IRQ = 1;
endpackage : virc_pkg

// >>> core/virc_link_if.sv
/*
 * link between the register block and the controller that drives it
 * assumes both ends share mclk; testbench instantiates and joins them
 */
`timescale 1ns/10ps
interface virc_link_if (input wire logic mclk);
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic irq_req;
    logic [2:0] irq_level;
    logic [7:0] irq_vector;
    modport device (input addr, wdata, wr, rd,
                    output rdata, irq_req, irq_level, irq_vector);
    modport host (output addr, wdata, wr, rd,
                  input rdata, irq_req, irq_level, irq_vector);
endinterface : virc_link_if

// >>> core/virc_device.sv
/*
 * interrupt routing and configuration registers, local and VME ports
 * assumes pins arrive asynchronously; link strobes come from mclk logic
 */
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
module virc_device
    import virc_pkg::*;
#(
    parameter logic [7:0] REVISION_CODE = 8'h5a // arbitrary value
)
(
    input wire logic mclk,
    input wire logic srst,
    virc_link_if.device link,
    input wire logic [7:1] vme_irq,
    input wire logic [7:1] local_interrupt_line,
    input wire logic ack_received,
    input wire logic dma_done,
    input wire logic sysfail_in,
    input wire logic arb_timeout,
    input wire logic write_post_fail,
    input wire logic ac_fail,
    input wire logic [3:0] global_switch,
    input wire logic [3:0] module_switch,
    input wire logic [7:0] vme_addr,
    input wire logic [31:0] vme_wdata,
    input wire logic vme_wr,
    input wire logic vme_rd,
    output logic [31:0] vme_rdata,
    output logic sysfail_out
);
    typedef struct packed {
        logic [NREG-1:0][7:0] regs;
        logic [NPIN-1:0] s1;
        logic [NPIN-1:0] s2;
        logic [NPIN-1:0] s3;
        logic [3:0] pend;
        logic [31:0] rdata;
        logic [31:0] vrdata;
        logic irq_req;
        logic [2:0] irq_level;
        logic [7:0] irq_vector;
        logic sysfail;
    } virc_dev_state_type;

    virc_dev_state_type q_reg;
    virc_dev_state_type q_next;
    logic [NPIN-1:0] pins;

    assign pins = {module_switch, global_switch, ac_fail, write_post_fail,
                   arb_timeout, sysfail_in, dma_done, ack_received,
                   local_interrupt_line, vme_irq};

    // readback with reserved, live and read-only fields applied
    function automatic logic [7:0] virc_read_byte(
        input virc_dev_state_type st,
        input logic [7:0] ix
    );
        logic [7:0] r;
        logic [7:0] line;
        r = 8'h00;
        line = ix - IX_LL1;
        if (ix < 8'(NREG))
        begin
            r = st.regs[ix];
        end
        if (ix >= 8'(NREG))
        begin
            r = 8'h00;
        end
        else if (ix <= IX_DMA)
        begin
            r = r | RSV_ONES;
        end
        else if (ix <= IX_LL7)
        begin
            r[LIVE_BIT] = st.s2[P_LINE + int'(line[2:0])];
        end
        else if (ix == IX_GSW || ix == IX_MSW)
        begin
            r = r | ONE3;
        end
        else if (ix == IX_ERR)
        begin
            r[LIVE_BIT] = st.s2[P_SYSF];
        end
        else if (ix >= IX_GSWVB && ix <= IX_ERRVB)
        begin
            r = r & ~VB_RO;
        end
        else if (ix == IX_REV)
        begin
            r = REVISION_CODE;
        end
        else if (ix == IX_RFC)
        begin
            r = (r & RFC_KEEP) | RFC_ONES;
            r[MASK_BIT] = st.sysfail;
        end
        return r;
    endfunction : virc_read_byte

    always_comb
    begin
        logic [NPIN-1:0] rise;
        logic [NSRC-1:0] src_on;
        logic [NSRC-1:0][2:0] src_lvl;
        logic [NSRC-1:0][7:0] src_vec;
        logic [7:0] gvb;
        logic [7:0] mvb;
        logic [7:0] evb;
        logic [7:0] ll7;
        logic [3:0] clr;
        logic [3:0] set;
        logic [2:0] best;
        logic [7:0] bvec;
        logic found;
        rise = q_reg.s2 & ~q_reg.s3;
        src_on = '0;
        src_lvl = '0;
        src_vec = '0;
        clr = 4'h0;
        set = 4'h0;
        best = 3'h0;
        bvec = 8'h00;
        found = 1'b0;
        gvb = q_reg.regs[IX_GSWVB];
        mvb = q_reg.regs[IX_MSWVB];
        evb = q_reg.regs[IX_ERRVB];
        ll7 = q_reg.regs[IX_LL7];
        q_next = q_reg;
        q_next.s1 = pins;
        q_next.s2 = q_reg.s1;
        q_next.s3 = q_reg.s2;

        // reads: data stands only in the cycle after the strobe
        q_next.rdata = 32'h0;
        if (link.rd)
        begin
            q_next.rdata = {24'h0, virc_read_byte(q_reg, link.addr)};
        end
        q_next.vrdata = 32'h0;
        if (vme_rd)
        begin
            q_next.vrdata = {virc_read_byte(q_reg, vme_addr), 24'h0};
        end

        // VME side writes: general bytes, flags and the fail bit only
        if (vme_wr)
        begin
            if ((vme_addr >= IX_GP0 && vme_addr <= IX_GP4)
                || vme_addr == IX_FLAGS)
            begin
                q_next.regs[vme_addr] = vme_wdata[31:24];
            end
            else if (vme_addr == IX_RFC)
            begin
                q_next.regs[IX_RFC] = (q_reg.regs[IX_RFC] & ~RFC_VME_WR)
                    | (vme_wdata[31:24] & RFC_VME_WR);
            end
        end

        // local writes win a same-cycle collision
        if (link.wr && link.addr < 8'(NREG) && link.addr != IX_REV)
        begin
            q_next.regs[link.addr] = link.wdata[7:0];
            if (link.addr == IX_ACK)
            begin
                clr[PD_ACK] = 1'b1;
            end
            if (link.addr == IX_DMA)
            begin
                clr[PD_DMA] = 1'b1;
            end
            if (link.addr == IX_ERR)
            begin
                clr[PD_ARB] = 1'b1;
                clr[PD_WPF] = 1'b1;
            end
        end

        // held events: a new edge beats a clearing write
        set[PD_ACK] = rise[P_ACK];
        set[PD_DMA] = rise[P_DMA];
        set[PD_ARB] = rise[P_ARB];
        set[PD_WPF] = rise[P_WPF];
        q_next.pend = (q_reg.pend & ~clr) | set;
        q_next.regs[IX_FLAGS] = q_next.regs[IX_FLAGS]
            | {rise[P_GSW +: NSW], rise[P_MSW +: NSW]};

        // source table from current state
        src_on[S_ACK] = q_reg.pend[PD_ACK] & ~q_reg.regs[IX_ACK][MASK_BIT];
        src_lvl[S_ACK] = q_reg.regs[IX_ACK][2:0];
        src_vec[S_ACK] = 8'(S_ACK);
        src_on[S_DMA] = q_reg.pend[PD_DMA] & ~q_reg.regs[IX_DMA][MASK_BIT];
        src_lvl[S_DMA] = q_reg.regs[IX_DMA][2:0];
        src_vec[S_DMA] = 8'(S_DMA);
        for (int k = 0; k < NLINE; k++)
        begin
            src_on[S_VLVL + k] = q_reg.s2[P_VIRQ + k]
                & ~q_reg.regs[int'(IX_VLVL1) + k][MASK_BIT];
            src_lvl[S_VLVL + k] = q_reg.regs[int'(IX_VLVL1) + k][2:0];
            src_vec[S_VLVL + k] = 8'(S_VLVL + k);
            src_on[S_LL + k] = q_reg.s2[P_LINE + k]
                & ~q_reg.regs[int'(IX_LL1) + k][MASK_BIT];
            src_lvl[S_LL + k] = q_reg.regs[int'(IX_LL1) + k][2:0];
            src_vec[S_LL + k] = {q_reg.regs[IX_LLVB][7:3], 3'(k + 1)};
        end
        for (int k = 0; k < NSW; k++)
        begin
            src_on[S_GSW + k] = q_reg.regs[IX_FLAGS][NSW + k]
                & ~q_reg.regs[IX_GSW][NSW + k];
            src_lvl[S_GSW + k] = q_reg.regs[IX_GSW][2:0];
            src_vec[S_GSW + k] = {gvb[7:2], 2'(k)};
            src_on[S_MSW + k] = q_reg.regs[IX_FLAGS][k]
                & ~q_reg.regs[IX_MSW][NSW + k];
            src_lvl[S_MSW + k] = q_reg.regs[IX_MSW][2:0];
            src_vec[S_MSW + k] = {mvb[7:2], 2'(k)};
            src_lvl[S_ERR + k] = q_reg.regs[IX_ERR][2:0];
            src_vec[S_ERR + k] = {evb[7:2], 2'(k)};
        end
        src_on[S_ERR] = q_reg.s2[P_SYSF] & ~q_reg.regs[IX_ERR][EM_SYSF];
        src_on[S_ERR + 1] = q_reg.pend[PD_ARB]
            & ~q_reg.regs[IX_ERR][EM_SYSF + 1];
        src_on[S_ERR + 2] = q_reg.pend[PD_WPF]
            & ~q_reg.regs[IX_ERR][EM_SYSF + 2];
        src_on[S_ERR + 3] = q_reg.s2[P_ACF]
            & ~q_reg.regs[IX_ERR][EM_SYSF + 3];

        // highest level wins, lowest source number on a tie; level 0 is off
        for (int k = 0; k < NSRC; k++)
        begin
            if (src_on[k] && src_lvl[k] > best)
            begin
                best = src_lvl[k];
                bvec = src_vec[k];
                found = 1'b1;
            end
        end
        q_next.irq_req = found;
        q_next.irq_level = best;
        q_next.irq_vector = bvec;

        q_next.sysfail = q_reg.regs[IX_RFC][FAIL_BIT] & ~ll7[MASK_BIT];

        if (srst)
        begin
            q_next = '0;
            q_next.regs[IX_RFC] = RFC_RESET;
        end
    end

    always_ff @(posedge mclk)
    begin
        q_reg <= q_next;
    end

    assign link.rdata = q_reg.rdata;
    assign link.irq_req = q_reg.irq_req;
    assign link.irq_level = q_reg.irq_level;
    assign link.irq_vector = q_reg.irq_vector;
    assign vme_rdata = q_reg.vrdata;
    assign sysfail_out = q_reg.sysfail;
endmodule : virc_device

// >>> core/virc_host.sv
/*
 * controller end: software queues one link access at a time and is told
 * of completion and of device interrupt requests through its own registers
 * assumes the device end sits on the same mclk
 */
`timescale 1ns/10ps
module virc_host
    import virc_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    virc_link_if.host link,
    input wire logic [3:0] sw_addr,
    input wire logic [31:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [31:0] sw_rdata,
    output logic irq
);
    typedef enum logic [2:0] {
        HS_IDLE = 3'b001,
        HS_ISSUE = 3'b010,
        HS_CAPT = 3'b100
    } virc_hstate_type;

    typedef struct packed {
        virc_hstate_type st;
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
        logic op_rd;
        logic [31:0] rdata;
        logic [1:0] stat;
        logic [1:0] en;
        logic req_seen;
        logic irq;
        logic [31:0] sw_rdata;
    } virc_host_state_type;

    virc_host_state_type q_reg;
    virc_host_state_type q_next;

    always_comb
    begin
        logic [1:0] clr;
        logic [1:0] set;
        clr = 2'b00;
        set = 2'b00;
        q_next = q_reg;
        q_next.wr = 1'b0;
        q_next.rd = 1'b0;
        q_next.req_seen = link.irq_req;
        q_next.sw_rdata = 32'h0;
        if (sw_rd)
        begin
            unique case (sw_addr)
                HA_ADDR: q_next.sw_rdata = {24'h0, q_reg.addr};
                HA_WDATA: q_next.sw_rdata = q_reg.wdata;
                HA_RDATA: q_next.sw_rdata = q_reg.rdata;
                HA_STAT: q_next.sw_rdata = {30'h0, q_reg.stat};
                HA_EN: q_next.sw_rdata = {30'h0, q_reg.en};
                HA_INFO: q_next.sw_rdata = {19'h0, q_reg.st != HS_IDLE,
                    link.irq_req, link.irq_level, link.irq_vector};
                default: q_next.sw_rdata = 32'h0;
            endcase
        end
        if (sw_wr)
        begin
            if (sw_addr == HA_ADDR && q_reg.st == HS_IDLE)
            begin
                q_next.addr = sw_wdata[7:0];
            end
            if (sw_addr == HA_WDATA && q_reg.st == HS_IDLE)
            begin
                q_next.wdata = sw_wdata;
            end
            if (sw_addr == HA_CLR)
            begin
                clr = sw_wdata[1:0];
            end
            if (sw_addr == HA_EN)
            begin
                q_next.en = sw_wdata[1:0];
            end
        end
        unique case (q_reg.st)
            HS_IDLE:
            begin
                if (sw_wr && sw_addr == HA_CMD
                    && (sw_wdata[CMD_WR] || sw_wdata[CMD_RD]))
                begin
                    q_next.wr = sw_wdata[CMD_WR];
                    q_next.rd = ~sw_wdata[CMD_WR];
                    q_next.op_rd = ~sw_wdata[CMD_WR];
                    q_next.st = HS_ISSUE;
                end
            end
            HS_ISSUE:
            begin
                q_next.st = HS_CAPT;
            end
            HS_CAPT:
            begin
                if (q_reg.op_rd)
                begin
                    q_next.rdata = link.rdata;
                end
                set[ST_DONE] = 1'b1;
                q_next.st = HS_IDLE;
            end
        endcase
        set[ST_IRQ] = link.irq_req & ~q_reg.req_seen;
        q_next.stat = (q_reg.stat & ~clr) | set;
        q_next.irq = |(q_next.stat & q_next.en);
        if (srst)
        begin
            q_next = '0;
            q_next.st = HS_IDLE;
        end
    end

    always_ff @(posedge mclk)
    begin
        q_reg <= q_next;
    end

    assign link.addr = q_reg.addr;
    assign link.wdata = q_reg.wdata;
    assign link.wr = q_reg.wr;
    assign link.rd = q_reg.rd;
    assign sw_rdata = q_reg.sw_rdata;
    assign irq = q_reg.irq;
endmodule : virc_host

// >>> verification/virc_link_properties.sv
/*
 * concurrent checks on the link between the register block and its controller
 * assumes instantiation beside the link interface, on mclk and srst
 */
`timescale 1ns/10ps
module virc_link_properties
    import virc_pkg::*;
#(
    parameter logic [7:0] REVISION_CODE = 8'h5a // arbitrary value
)
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic irq_req,
    input wire logic [2:0] irq_level,
    input wire logic [7:0] irq_vector
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);
    a_rdata_idle_zero: assert property (!rd |=> rdata == 32'h0)
        else $error("read data outside its answer cycle");
    a_rdata_low_lane: assert property (rd |=> rdata[31:8] == 24'h0)
        else $error("read data outside the low byte lane");
    a_reserved_ones: assert property (rd && addr <= IX_DMA
        |=> rdata[6:3] == 4'hf)
        else $error("reserved control bits not ones");
    a_switch_bit_one: assert property (
        rd && (addr == IX_GSW || addr == IX_MSW) |=> rdata[3])
        else $error("switch control bit 3 not one");
    a_vbase_low_zero: assert property (
        rd && addr >= IX_GSWVB && addr <= IX_ERRVB |=> rdata[1:0] == 2'h0)
        else $error("vector base low bits not zero");
    a_rev_code: assert property (
        rd && addr == IX_REV |=> rdata[7:0] == REVISION_CODE)
        else $error("revision code wrong");
    a_rfc_ones: assert property (
        rd && addr == IX_RFC |=> rdata[5:2] == 4'hf)
        else $error("reset control bits 5-2 not ones");
    a_req_level: assert property (irq_req == (irq_level != 3'h0))
        else $error("request and level disagree");
    a_vector_idle: assert property (!irq_req |-> irq_vector == 8'h00)
        else $error("vector shown without a request");
    c_rfc_read: cover property (rd && addr == IX_RFC);
    c_req_five: cover property (irq_req && irq_level == 3'h5);
    c_wr_then_rd: cover property (wr ##[1:20] rd);
endmodule : virc_link_properties

// >>> verification/tb_top.sv
/*
 * testbench joining controller and register block; software port tests
 * assumes one mclk and a synchronous active-high srst
 */
`timescale 1ns/10ps
module tb_top;
    import virc_pkg::*;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] sw_addr = 4'h0;
    logic [31:0] sw_wdata = 32'h0;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    logic [31:0] sw_rdata;
    logic irq;
    logic [7:0] ev = 8'h00;
    logic [7:1] lines = 7'h00;
    logic sysf = 1'b0;
    logic [3:0] gsw = 4'h0;
    logic [7:0] v_addr = 8'h00;
    logic [31:0] v_wdata = 32'h0;
    logic v_wr = 1'b0;
    logic v_rd = 1'b0;
    logic [31:0] v_rdata;
    logic sysfail_out;
    logic [31:0] d;
    int miscompares = 0;
    int num_checks = 0;
    int i;
    always #5 mclk = ~mclk;
    virc_link_if link (.mclk(mclk));
    virc_device #(.REVISION_CODE(8'ha7)) virc_device_inst (
        .mclk(mclk), .srst(srst), .link(link), .vme_irq(ev[7:1]),
        .local_interrupt_line(lines), .ack_received(ev[0]),
        .dma_done(ev[1]), .sysfail_in(sysf), .arb_timeout(ev[2]),
        .write_post_fail(ev[3]), .ac_fail(ev[4]), .global_switch(gsw),
        .module_switch(ev[3:0]), .vme_addr(v_addr), .vme_wdata(v_wdata),
        .vme_wr(v_wr), .vme_rd(v_rd), .vme_rdata(v_rdata),
        .sysfail_out(sysfail_out));
    virc_host virc_host_inst (
        .mclk(mclk), .srst(srst), .link(link), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
        .sw_rdata(sw_rdata), .irq(irq));
    virc_link_properties #(.REVISION_CODE(8'ha7)) virc_link_properties_inst (
        .mclk(mclk), .srst(srst), .addr(link.addr), .wdata(link.wdata),
        .wr(link.wr), .rd(link.rd), .rdata(link.rdata),
        .irq_req(link.irq_req), .irq_level(link.irq_level),
        .irq_vector(link.irq_vector));
    task automatic complete_run();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic sw_write(input logic [3:0] a, input logic [31:0] v);
        @(posedge mclk);
        sw_addr <= a;
        sw_wdata <= v;
        sw_wr <= 1'b1;
        @(posedge mclk);
        sw_wr <= 1'b0;
    endtask : sw_write
    task automatic sw_read(input logic [3:0] a, output logic [31:0] v);
        @(posedge mclk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge mclk);
        sw_rd <= 1'b0;
        #1 v = sw_rdata;
    endtask : sw_read
    // one register access through the controller, polled to completion
    task automatic dev(input int op, input logic [7:0] ix, input logic [7:0] b);
        sw_write(HA_ADDR, {24'h0, ix});
        sw_write(HA_WDATA, {24'h0, b});
        sw_write(HA_CMD, 32'h1 << op);
        d = 32'h0;
        for (int k = 0; k < 8 && d[ST_DONE] !== 1'b1; k++)
            sw_read(HA_STAT, d);
        chk(d & 32'h1, 32'h1);
        sw_write(HA_CLR, 32'h1);
        if (op == CMD_RD)
            sw_read(HA_RDATA, d);
    endtask : dev
    task automatic rdchk(input logic [7:0] ix, input logic [7:0] exp);
        dev(CMD_RD, ix, 8'h00);
        chk(d, {24'h0, exp});
    endtask : rdchk
    task automatic vme(input logic w, input logic [7:0] ix, input logic [7:0] b);
        @(posedge mclk);
        v_addr <= ix;
        v_wdata <= {b, 24'h0};
        v_wr <= w;
        v_rd <= !w;
        @(posedge mclk);
        v_wr <= 1'b0;
        v_rd <= 1'b0;
        #1 d = v_rdata;
    endtask : vme
    // request, level and vector as the controller reports them
    task automatic info(input logic [11:0] exp);
        repeat (6) @(posedge mclk);
        sw_read(HA_INFO, d);
        chk(d & 32'hfff, {20'h0, exp});
    endtask : info
    initial
    begin
        #200000;
        miscompares++;
        complete_run();
    end
    initial
    begin
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        for (i = 0; i < 9; i++)
            rdchk(i[7:0], RSV_ONES);
        rdchk(IX_LL1, 8'h00);
        rdchk(IX_GSW, ONE3);
        rdchk(IX_MSW, ONE3);
        rdchk(IX_ERR, 8'h00);
        rdchk(IX_REV, 8'ha7);
        rdchk(IX_RFC, 8'hff);
        chk({31'h0, sysfail_out}, 32'h1);
        $display("test reset_values done");
        for (i = 0; i < 9; i++)
        begin
            dev(CMD_WR, i[7:0], 8'h80 | i[7:0]);
            rdchk(i[7:0], 8'hf8 | (i[7:0] & 8'h07));
        end
        @(posedge mclk);
        lines <= 7'h7f;
        for (i = 9; i < 16; i++)
        begin
            dev(CMD_WR, i[7:0], 8'h97);
            rdchk(i[7:0], 8'h9f);
        end
        for (i = 19; i < 23; i++)
        begin
            dev(CMD_WR, i[7:0], 8'hff);
            rdchk(i[7:0], 8'hfc);
        end
        dev(CMD_WR, IX_REV, 8'h00);
        rdchk(IX_REV, 8'ha7);
        rdchk(8'h1f, 8'h00);
        $display("test field_layout done");
        dev(CMD_WR, IX_RFC, 8'h00);
        rdchk(IX_RFC, RFC_ONES);
        chk({31'h0, sysfail_out}, 32'h0);
        dev(CMD_WR, IX_LL7, 8'h10);
        vme(1'b1, IX_RFC, 8'h43);
        #20;
        chk({31'h0, sysfail_out}, 32'h1);
        dev(CMD_WR, IX_LL7, 8'h90);
        vme(1'b0, IX_RFC, 8'h00);
        chk(d, 32'h7c000000);
        chk({31'h0, sysfail_out}, 32'h0);
        $display("test reset_fail done");
        vme(1'b1, IX_GP0, 8'h3c);
        rdchk(IX_GP0, 8'h3c);
        dev(CMD_WR, IX_GP4, 8'hc3);
        vme(1'b0, IX_GP4, 8'h00);
        chk(d, 32'hc3000000);
        vme(1'b0, IX_REV, 8'h00);
        chk(d, 32'ha7000000);
        $display("test both_sides done");
        sw_write(HA_EN, 32'h2);
        dev(CMD_WR, 8'h0b, 8'h15);
        info(12'hdfb);
        chk({31'h0, irq}, 32'h1);
        dev(CMD_WR, 8'h0b, 8'h95);
        info(12'h000);
        sw_write(HA_CLR, 32'h2);
        #11;
        chk({31'h0, irq}, 32'h0);
        dev(CMD_WR, IX_GSW, 8'h03);
        @(posedge mclk);
        gsw <= 4'h2;
        info(12'hbfd);
        rdchk(IX_FLAGS, 8'h20);
        dev(CMD_WR, IX_FLAGS, 8'h00);
        info(12'h000);
        dev(CMD_WR, IX_ERR, 8'hf2);
        dev(CMD_WR, IX_DMA, 8'h04);
        @(posedge mclk);
        sysf <= 1'b1;
        ev <= 8'hff;
        rdchk(IX_ERR, 8'hfa);
        info(12'hc08);
        dev(CMD_WR, IX_DMA, 8'h84);
        dev(CMD_WR, IX_ERR, 8'he2);
        info(12'hafc);
        dev(CMD_WR, IX_VLVL1 + 8'h02, 8'h06);
        info(12'he03);
        dev(CMD_WR, IX_ACK, 8'h07);
        @(posedge mclk);
        ev <= 8'hfe;
        repeat (4) @(posedge mclk);
        ev <= 8'hff;
        info(12'hf00);
        $display("test interrupts done");
        @(posedge mclk);
        srst <= 1'b1;
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        rdchk(IX_RFC, 8'hff);
        chk({31'h0, sysfail_out}, 32'h1);
        info(12'h000);
        $display("test mid_reset done");
        complete_run();
    end
endmodule : tb_top
